/* src/comparator_mode_irq_config.sv */
// comparator mode select register with rising and falling edge interrupt enables
// assumes the special function register bus: one access per cycle, page and
// address valid with the strobe, read data expected one cycle later
`timescale 1ns/1ps

module comparator_mode_irq_config
    import cmp_mode_pkg::*;
(
    // clock, reset and clock enable
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // special function register bus
    input  wire logic [3:0] sfr_page,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_rd_valid,
    // comparator side
    input  wire logic       cmp_out,
    output logic      [1:0] speed_mode_field,
    output logic            rise_irq_enable,
    output logic            fall_irq_enable,
    output logic            cmp_irq
);

    // ****************************************
    // decode
    // ****************************************
    function automatic logic reg_hit(input logic [3:0] page, input logic [7:0] addr);
        reg_hit = (page == MODE_SELECT_PAGE) && (addr == MODE_SELECT_ADDR);
    endfunction : reg_hit

    logic wr_hit;
    logic rd_hit;
    logic rise_evt;
    logic fall_evt;
    logic next_irq;
    logic [7:0] read_image;

    assign wr_hit = clk_en && sfr_wr && reg_hit(sfr_page, sfr_addr);
    assign rd_hit = clk_en && sfr_rd && reg_hit(sfr_page, sfr_addr);

    // ****************************************
    // register storage
    // ****************************************
    // only the writable fields are stored; the fixed bits cost no flops
    always_ff @(posedge clk) begin
        if (reset) begin
            rise_irq_enable <= RISE_IE_RESET;
            fall_irq_enable <= FALL_IE_RESET;
            speed_mode_field <= MODE_RESET;
        end else if (wr_hit) begin
            rise_irq_enable  <= sfr_wdata[RISE_IE_BIT];
            fall_irq_enable  <= sfr_wdata[FALL_IE_BIT];
            speed_mode_field <= sfr_wdata[MODE_MSB:MODE_LSB];
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        read_image = '0;
        read_image[RESERVED_BIT] = RESERVED_READ;
        read_image[UNUSED_HI_BIT] = UNUSED_READ;
        read_image[UNUSED_LO_MSB:UNUSED_LO_LSB] = {2{UNUSED_READ}};
        read_image[RISE_IE_BIT] = rise_irq_enable;
        read_image[FALL_IE_BIT] = fall_irq_enable;
        read_image[MODE_MSB:MODE_LSB] = speed_mode_field;
    end

    // read data holds until the next read of this register
    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rdata    <= 8'h00;
            sfr_rd_valid <= 1'b0;
        end else if (clk_en) begin
            sfr_rd_valid <= rd_hit;
            if (rd_hit) begin
                sfr_rdata <= read_image;
            end
        end
    end

    // ****************************************
    // edge interrupt
    // ****************************************
    cmp_edge_detect u_edge (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .cmp_level (cmp_out),
        .rise_evt  (rise_evt),
        .fall_evt  (fall_evt)
    );

    // either enabled edge alone raises the request
    assign next_irq = (rise_evt && rise_irq_enable)
                   || (fall_evt && fall_irq_enable);

    // a one-cycle pulse; the interrupt controller owns the sticky flag
    always_ff @(posedge clk) begin
        if (reset) begin
            cmp_irq <= 1'b0;
        end else if (clk_en) begin
            cmp_irq <= next_irq;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_reserved_reads_one: assert property (@(posedge clk) disable iff (reset)
        sfr_rd_valid |-> sfr_rdata[RESERVED_BIT] == 1'b1)
        else $error("reserved bit did not read as one");

    a_bit6_reads_zero: assert property (@(posedge clk) disable iff (reset)
        (wr_hit && sfr_wdata[UNUSED_HI_BIT]) ##1 (clk_en && sfr_rd && reg_hit(sfr_page, sfr_addr))
        |=> sfr_rdata[UNUSED_HI_BIT] == 1'b0)
        else $error("bit 6 did not read as zero after a write of one");

    a_low_unused_zero: assert property (@(posedge clk) disable iff (reset)
        sfr_rd_valid |-> sfr_rdata[UNUSED_LO_MSB:UNUSED_LO_LSB] == 2'h0)
        else $error("bits 3:2 did not read as zero");

    a_rise_enable_write: assert property (@(posedge clk) disable iff (reset)
        wr_hit |=> rise_irq_enable == $past(sfr_wdata[RISE_IE_BIT]))
        else $error("rise enable did not take the written value");

    a_fall_enable_write: assert property (@(posedge clk) disable iff (reset)
        wr_hit |=> fall_irq_enable == $past(sfr_wdata[FALL_IE_BIT]))
        else $error("fall enable did not take the written value");

    a_mode_write_read: assert property (@(posedge clk) disable iff (reset)
        wr_hit ##1 rd_hit |=> sfr_rd_valid && sfr_rdata[MODE_MSB:MODE_LSB] == $past(sfr_wdata[MODE_MSB:MODE_LSB], 2))
        else $error("mode field read back differs from the value written");

    a_rise_raises_irq: assert property (@(posedge clk) disable iff (reset)
        (clk_en && rise_evt && rise_irq_enable) |=> cmp_irq)
        else $error("enabled rising edge did not raise the interrupt");

    a_fall_raises_irq: assert property (@(posedge clk) disable iff (reset)
        (clk_en && fall_evt && fall_irq_enable) |=> cmp_irq)
        else $error("enabled falling edge did not raise the interrupt");

    a_irq_has_cause: assert property (@(posedge clk) disable iff (reset)
        $rose(cmp_irq) |-> $past((rise_evt && rise_irq_enable) || (fall_evt && fall_irq_enable)))
        else $error("interrupt raised without an enabled edge");

    a_reset_image: assert property (@(posedge clk)
        reset |=> speed_mode_field == MODE_RESET && !rise_irq_enable && !fall_irq_enable)
        else $error("register fields not at reset values after reset");

    // ****************************************
    // read path checks
    // ****************************************
    // the fixed bits are checked above; these make sure the answer itself is well formed

    a_read_answers: assert property (@(posedge clk) disable iff (reset)
        rd_hit
        |=> sfr_rd_valid)
        else $error("read hit gave no read answer");

    a_no_stray_answer: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !rd_hit)
        |=> !sfr_rd_valid)
        else $error("read answer without a read hit");

    a_rdata_holds: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !rd_hit)
        |=> $stable(sfr_rdata))
        else $error("read data changed without a read hit");

    a_enables_read_back: assert property (@(posedge clk) disable iff (reset)
        rd_hit
        |=> sfr_rdata[RISE_IE_BIT] == $past(rise_irq_enable)
            && sfr_rdata[FALL_IE_BIT] == $past(fall_irq_enable))
        else $error("read data enables differ from the stored enables");

    // ****************************************
    // isolation, freeze and interrupt masking checks
    // ****************************************
    // a foreign write that leaked into the fields would silently retune the comparator

    a_foreign_write_ignored: assert property (@(posedge clk) disable iff (reset)
        (clk_en && sfr_wr && !reg_hit(sfr_page, sfr_addr))
        |=> $stable(speed_mode_field) && $stable(rise_irq_enable) && $stable(fall_irq_enable))
        else $error("write to another register changed the fields");

    a_freeze_fields: assert property (@(posedge clk) disable iff (reset)
        !clk_en
        |=> $stable(speed_mode_field) && $stable(rise_irq_enable) && $stable(fall_irq_enable))
        else $error("fields changed while the clock enable was low");

    a_freeze_irq: assert property (@(posedge clk) disable iff (reset)
        !clk_en
        |=> $stable(cmp_irq))
        else $error("interrupt changed while the clock enable was low");

    a_no_irq_disabled: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !rise_irq_enable && !fall_irq_enable)
        |=> !cmp_irq)
        else $error("interrupt raised with both enables low");

    a_rise_masked: assert property (@(posedge clk) disable iff (reset)
        (clk_en && rise_evt && !rise_irq_enable)
        |=> !cmp_irq)
        else $error("disabled rising edge raised the interrupt");

    a_fall_masked: assert property (@(posedge clk) disable iff (reset)
        (clk_en && fall_evt && !fall_irq_enable)
        |=> !cmp_irq)
        else $error("disabled falling edge raised the interrupt");

endmodule : comparator_mode_irq_config

/* src/cmp_mode_pkg.sv */
// constants for the comparator mode and edge-interrupt configuration register
// assumes an 8-bit special function register bus on the system clock
package cmp_mode_pkg;

    // ****************************************
    // register location
    // ****************************************
    localparam logic [7:0] MODE_SELECT_ADDR = 8'h9d;
    localparam logic [3:0] MODE_SELECT_PAGE = 4'h0;

    // ****************************************
    // field positions
    // ****************************************
    localparam int RESERVED_BIT  = 7;
    localparam int UNUSED_HI_BIT = 6;
    localparam int RISE_IE_BIT   = 5;
    localparam int FALL_IE_BIT   = 4;
    localparam int UNUSED_LO_MSB = 3;
    localparam int UNUSED_LO_LSB = 2;
    localparam int MODE_MSB      = 1;
    localparam int MODE_LSB      = 0;

    // ****************************************
    // values after reset and fixed read values
    // ****************************************
    localparam logic       RESERVED_READ = 1'b1;
    localparam logic       UNUSED_READ   = 1'b0;
    localparam logic       RISE_IE_RESET = 1'b0;
    localparam logic       FALL_IE_RESET = 1'b0;
    localparam logic [1:0] MODE_RESET    = 2'h2;
    localparam logic [7:0] REG_RESET     = 8'h82;

    // speed modes, fastest first
    typedef enum logic [1:0] {
        SPEED_FASTEST,
        SPEED_MEDIUM_FAST,
        SPEED_MEDIUM_SLOW,
        SPEED_LOWEST_POWER
    } speed_mode_t;

endpackage : cmp_mode_pkg

/* src/cmp_edge_detect.sv */
// synchroniser and edge detector for the asynchronous comparator output
// assumes the comparator level may change at any time relative to clk
`timescale 1ns/1ps

module cmp_edge_detect (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // comparator level from the analog side
    input  wire logic cmp_level,
    // one-cycle edge indications, valid while clk_en is high
    output logic      rise_evt,
    output logic      fall_evt
);

    logic sync_first;
    logic sync_second;
    logic level_last;

    // the first stage feeds only the second; edges are seen on stages two and three
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
            level_last  <= 1'b0;
        end else if (clk_en) begin
            sync_first  <= cmp_level;
            sync_second <= sync_first;
            level_last  <= sync_second;
        end
    end

    assign rise_evt = sync_second & ~level_last;
    assign fall_evt = ~sync_second & level_last;

endmodule : cmp_edge_detect

/* dv/tb_top.sv */
// self-checking bench for the comparator mode and edge-interrupt register
// assumes the register answers on page 0x0 at 0x9d with read data one cycle later
`timescale 1ns/1ps

module tb_top;
    import cmp_mode_pkg::*;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic       clk          = 1'b0;
    logic       reset        = 1'b1;
    logic       clk_en       = 1'b1;
    logic [3:0] sfr_page     = 4'h0;
    logic [7:0] sfr_addr     = 8'h00;
    logic       sfr_wr       = 1'b0;
    logic       sfr_rd       = 1'b0;
    logic [7:0] sfr_wdata    = 8'h00;
    logic       cmp_out      = 1'b0;
    logic [7:0] sfr_rdata;
    logic       sfr_rd_valid;
    logic [1:0] speed_mode_field;
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    logic       cmp_irq;
    int         miscompares  = 0;
    int         n_checks     = 0;
    integer     seed         = 77;
    logic [7:0] d;
    logic [7:0] last;
    int         n;

    always #25 clk = ~clk;

    comparator_mode_irq_config u_dut (
        .clk(clk), .reset(reset), .clk_en(clk_en), .sfr_page(sfr_page),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_rd_valid(sfr_rd_valid), .cmp_out(cmp_out),
        .speed_mode_field(speed_mode_field), .rise_irq_enable(rise_irq_enable),
        .fall_irq_enable(fall_irq_enable), .cmp_irq(cmp_irq));

    // ****************************************
    // helpers
    // ****************************************
    // fixed bits come from the bench, never from the design
    function automatic logic [7:0] exp_reg(input logic [7:0] w);
        return {1'b1, 1'b0, w[5:4], 2'b00, w[1:0]};
    endfunction : exp_reg

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    // one strobe cycle; outputs are settled when the task returns
    task automatic access(input logic w, input logic [3:0] pg, input logic [7:0] ad,
                          input logic [7:0] dat);
        @(posedge clk);
        sfr_wr    <= w;
        sfr_rd    <= !w;
        sfr_page  <= pg;
        sfr_addr  <= ad;
        sfr_wdata <= dat;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        #1;
    endtask : access

    task automatic edge_count(input logic lvl, output int cnt);
        @(posedge clk);
        cmp_out <= lvl;
        cnt = 0;
        repeat (6) begin
            @(posedge clk);
            #1;
            if (cmp_irq === 1'b1) cnt++;
        end
    endtask : edge_count

    task automatic summarize;
        if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        access(1'b0, 4'h0, 8'h9d, 8'h00);
        check({7'h00, sfr_rd_valid}, 8'h01, "read answer");
        check(sfr_rdata, 8'h82, "reset value");
        check({speed_mode_field, rise_irq_enable, fall_irq_enable}, 4'h8, "reset fields");
        for (int i = 0; i < 24; i++) begin
            d = 8'($random(seed));
            if (i < 4) d[1:0] = i[1:0];
            if (i == 4) d = 8'h80;
            d[7] = 1'b1;
            access(1'b1, 4'h0, 8'h9d, d);
            check({2'b00, speed_mode_field}, {6'h00, d[1:0]}, "speed mode");
            check({rise_irq_enable, fall_irq_enable}, d[5:4], "enables");
            access(1'b0, 4'h0, 8'h9d, 8'h00);
            check(sfr_rdata, exp_reg(d), "readback");
        end
        // write then read in adjacent cycles: the read must see the new value
        d = 8'($random(seed)) | 8'hc0;
        @(posedge clk);
        sfr_wr    <= 1'b1;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        check(sfr_rdata, exp_reg(d), "back to back");
        last = exp_reg(d);
        // writes elsewhere, or with the clock enable low, must leave the register alone
        access(1'b1, 4'h0, 8'h9c, {1'b1, ~d[6:0]});
        access(1'b1, 4'h1, 8'h9d, {1'b1, ~d[6:0]});
        clk_en <= 1'b0;
        access(1'b1, 4'h0, 8'h9d, {1'b1, ~d[6:0]});
        clk_en <= 1'b1;
        access(1'b0, 4'h0, 8'h9c, 8'h00);
        check({7'h00, sfr_rd_valid}, 8'h00, "foreign read");
        access(1'b0, 4'h0, 8'h9d, 8'h00);
        check(sfr_rdata, last, "unchanged");
        // every enable combination, each edge direction
        for (int i = 0; i < 4; i++) begin
            access(1'b1, 4'h0, 8'h9d, {2'b10, i[1:0], 4'h3});
            edge_count(1'b1, n);
            check(8'(n), {7'h00, i[1]}, "rise pulses");
            edge_count(1'b0, n);
            check(8'(n), {7'h00, i[0]}, "fall pulses");
        end
        summarize();
    end

    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize();
    end

endmodule : tb_top
